// ==== rtl/conv_sync_ctrl.v ====
`timescale 1ns/1ns
`include "conv_sync_defines.vh"
// Contract
// R1: reset by low reset pin of minimum width or by reset opcode.
// R2: reset opcode acts on the eighth falling serial clock edge.
// R3: 18 clocks after reset restore defaults, then conversions begin; the sequencer instead stays idle until a start.
// R4: writing rate/chain or respiration register resets the digital filter.
// R5: conversions start on start pin high two clocks or start opcode.
// R6: with no start, conversions halt and no data-ready pulse appears.
// R7: host keeps start pin low when using start and stop opcodes.
// R8: mode bit 3 selects continuous (0) or one conversion (1).
// R9: start drives data-ready high; next fall marks first settled result.
// R10: settling delay per rate code, 1160 up to 73736 clocks.
// R11: input step needs three output periods; fourth pulse is settled.
// R12: continuous mode runs until stop, finishing the conversion in progress.
// R13: start and stop opcodes act on the seventh falling clock edge.
// R14: stop must lead data-ready by 16 clocks; conversion ends 16 after.
// R15: host restarts conversions after changing the conversion mode.
// R16: one-conversion mode converts once, data-ready falls and stays low; a serial clock rise instead returns it high.
// R17: host pulses start or resends start opcode for another conversion.
// R18: each start resets the filter, so single results take four periods.
// R19: deselected device puts its serial output in high impedance.
// R20: chain-enable bit in rate/chain register selects daisy-chain mode.
// R21: chain frame order: own frame, one don't-care bit, then next device.
// R22: repeated readback is unavailable in daisy-chain mode.
// R23: in chain mode each rising clock shifts out and latches chain input.
// R24: clock master with clock-out enable supplies conversion clock to others.
// R25: frame starts with 24-bit status: 1100, lead-off bits, input levels.
// R26: opcodes are 08h start, 0Ah stop, 06h reset.
// R27: start while running and stop while halted are ignored.
module conv_sync_ctrl
(
  // conversion clock and reset
  input  wire         clk,
  input  wire         rstn,
  // device pins
  input  wire         reset_pin_n,
  input  wire         start_pin,
  input  wire         sclk,
  input  wire         cs_n,
  input  wire         sdi,
  input  wire         chain_in,
  output wire         sdo_out,
  output wire         sdo_oe,
  output reg          data_ready_n,
  // clock master
  input  wire         clock_source_select,
  input  wire         clk_out_en,
  output wire         clk_out,
  // front end status and result
  input  wire [15:0]  lead_off_bits,
  input  wire [3:0]   gpio_levels,
  input  wire [127:0] channel_data,
  // internal status
  output reg          filter_reset,
  output reg          converting,
  output reg          init_busy,
  output wire [2:0]   rate_select,
  output wire         chain_en,
  output wire         single_mode
);
  localparam ST_IDLE   = 2'h0;
  localparam ST_SETTLE = 2'h1;
  localparam ST_RUN    = 2'h2;

  reg         rst_meta_reg, rst_sync_reg;
  wire        rst_n = rst_sync_reg;
  reg  [2:0]  rpin_s_reg, spin_s_reg, sclk_s_reg, cs_s_reg, sdi_s_reg, ci_s_reg;
  reg  [7:0]  rate_chain_config_reg, misc_mode_config_reg, respiration_ctrl_reg;
  reg  [7:0]  cmd_reg;
  reg  [3:0]  bit_cnt_reg;
  reg  [1:0]  wstage_reg;
  reg  [4:0]  waddr_reg, init_cnt_reg, halt_cnt_reg;
  reg  [1:0]  high_cnt_reg;
  reg  [1:0]  state_reg;
  reg  [16:0] settle_cnt_reg;
  reg         pin_started_reg, stop_pend_reg, load_reg;
  reg  [16:0] settling_delay, period;
  wire        sclk_fall = sclk_s_reg[2] & ~sclk_s_reg[1];
  wire        sclk_rise = ~sclk_s_reg[2] & sclk_s_reg[1];
  wire        cs_act    = ~cs_s_reg[1];
  wire        spin      = spin_s_reg[1];
  wire [7:0]  cmd_now   = {cmd_reg[6:0], sdi_s_reg[1]};
  // opcodes decoded at the seventh falling edge look at seven bits
  wire        op7       = sclk_fall && cs_act && bit_cnt_reg == 4'h6 &&
                          wstage_reg == 2'h0;
  wire        op_start  = op7 && {cmd_now[6:0], 1'b0} == `OP_START; // [R13]
  wire        op_stop   = op7 && {cmd_now[6:0], 1'b0} == `OP_STOP;  // [R13]
  wire        byte8     = sclk_fall && cs_act && bit_cnt_reg == 4'h7;
  wire        op_reset  = byte8 && wstage_reg == 2'h0 &&
                          cmd_now == `OP_RESET; // [R2] [R26]
  wire        pin_rise_ok;
  wire        pin_fall  = spin_s_reg[2] & ~spin;

  assign rate_select = rate_chain_config_reg[`RATE_SEL_MSB:0];
  assign chain_en    = rate_chain_config_reg[`RATE_CHAIN_BIT]; // [R20]
  assign single_mode = misc_mode_config_reg[`MISC_SINGLE_BIT]; // [R8]
  // master with oscillator and clock-out enabled feeds the others
  assign clk_out     = clock_source_select & clk_out_en & clk; // [R24]

  // reset release through two flops
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // pin synchronisers; stage 2 exists only for edge detection
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rpin_s_reg <= 3'h7;
      spin_s_reg <= 3'h0;
      sclk_s_reg <= 3'h0;
      cs_s_reg   <= 3'h7;
      sdi_s_reg  <= 3'h0;
      ci_s_reg   <= 3'h0;
    end
    else
    begin
      rpin_s_reg <= {rpin_s_reg[1:0], reset_pin_n};
      spin_s_reg <= {spin_s_reg[1:0], start_pin};
      sclk_s_reg <= {sclk_s_reg[1:0], sclk};
      cs_s_reg   <= {cs_s_reg[1:0], cs_n};
      sdi_s_reg  <= {sdi_s_reg[1:0], sdi};
      ci_s_reg   <= {ci_s_reg[1:0], chain_in};
    end
  end

  // settling delay table by rate code
  always @*
  begin
    case (rate_select)
      3'h0:    settling_delay = `SETTLE_000; // [R10]
      3'h1:    settling_delay = `SETTLE_001;
      3'h2:    settling_delay = `SETTLE_010;
      3'h3:    settling_delay = `SETTLE_011;
      3'h4:    settling_delay = `SETTLE_100;
      3'h5:    settling_delay = `SETTLE_101;
      default: settling_delay = `SETTLE_110;
    endcase
    // output period approximated as a quarter of the settling time
    period = {2'h0, settling_delay[16:2]}; // [R11] [R18]
  end

  // start pin must stay high two clocks before it counts
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      high_cnt_reg    <= 2'h0;
      pin_started_reg <= 1'b0;
    end
    else if (!spin)
    begin
      high_cnt_reg    <= 2'h0;
      pin_started_reg <= 1'b0;
    end
    else if (high_cnt_reg != `START_MIN_HIGH)
      high_cnt_reg <= high_cnt_reg + 2'h1;
    else
      pin_started_reg <= 1'b1;
  end
  assign pin_rise_ok = spin && high_cnt_reg == `START_MIN_HIGH - 2'h1 &&
                       !pin_started_reg; // [R5] [R17]

  // command byte shifter and register-write decode
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmd_reg               <= 8'h00;
      bit_cnt_reg           <= 4'h0;
      wstage_reg            <= 2'h0;
      waddr_reg             <= 5'h00;
      rate_chain_config_reg <= `RATE_CHAIN_RST;
      misc_mode_config_reg  <= `MISC_MODE_RST;
      respiration_ctrl_reg  <= `RESPIRATION_CTRL_REG_RST;
    end
    else if (init_busy)
    begin
      // defaults are held while initialisation runs
      rate_chain_config_reg <= `RATE_CHAIN_RST; // [R3]
      misc_mode_config_reg  <= `MISC_MODE_RST;
      respiration_ctrl_reg  <= `RESPIRATION_CTRL_REG_RST;
      bit_cnt_reg           <= 4'h0;
      wstage_reg            <= 2'h0;
    end
    else if (!cs_act)
    begin
      bit_cnt_reg <= 4'h0;
      wstage_reg  <= 2'h0;
    end
    else if (sclk_fall)
    begin
      cmd_reg     <= cmd_now;
      bit_cnt_reg <= (bit_cnt_reg == 4'h7) ? 4'h0 : bit_cnt_reg + 4'h1;
      if (byte8)
      begin
        case (wstage_reg)
          2'h0:
          begin
            if (cmd_now[7:5] == `OP_REGISTER_WRITE_CMD_HI)
            begin
              waddr_reg  <= cmd_now[4:0];
              wstage_reg <= 2'h1;
            end
          end
          2'h1: wstage_reg <= 2'h2; // single register count assumed
          2'h2:
          begin
            wstage_reg <= 2'h0;
            if (waddr_reg == `ADDR_RATE_CHAIN)
              rate_chain_config_reg <= cmd_now;
            else if (waddr_reg == `ADDR_RESPIRATION_CTRL_REG)
              respiration_ctrl_reg <= cmd_now;
            else if (waddr_reg == `ADDR_MISC_MODE)
              misc_mode_config_reg <= cmd_now;
          end
          default: wstage_reg <= 2'h0;
        endcase
      end
    end
  end

  // conversion sequencer
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg      <= ST_IDLE;
      settle_cnt_reg <= 17'h0;
      stop_pend_reg  <= 1'b0;
      halt_cnt_reg   <= 5'h0;
      init_cnt_reg   <= `RESET_CYCLES;
      init_busy      <= 1'b1;
      data_ready_n   <= 1'b1;
      filter_reset   <= 1'b0;
      converting     <= 1'b0;
      load_reg       <= 1'b0;
    end
    else
    begin
      filter_reset <= 1'b0;
      load_reg     <= 1'b0;
      // serial clock rise returns data-ready high
      if (sclk_rise && !data_ready_n)
        data_ready_n <= 1'b1;
      if (!rpin_s_reg[1] || op_reset)
      begin
        init_cnt_reg <= `RESET_CYCLES; // [R1]
        init_busy    <= 1'b1;
        state_reg    <= ST_IDLE;
        converting   <= 1'b0;
        data_ready_n <= 1'b1;
        filter_reset <= 1'b1;
      end
      else if (init_busy)
      begin
        if (init_cnt_reg == 5'h01)
          init_busy <= 1'b0; // [R3]
        init_cnt_reg <= init_cnt_reg - 5'h01;
      end
      else
      begin
        if (byte8 && wstage_reg == 2'h2 &&
            (waddr_reg == `ADDR_RATE_CHAIN || waddr_reg == `ADDR_RESPIRATION_CTRL_REG))
          filter_reset <= 1'b1; // [R4]
        // stop request latched, honoured at the end of this conversion unless it comes in its last 16 clocks
        if ((op_stop || pin_fall) && converting)
        begin
          stop_pend_reg <= 1'b1; // [R12] [R27]
          halt_cnt_reg  <= `HALT_FINISH;
        end
        else if (halt_cnt_reg != 5'h0)
          halt_cnt_reg <= halt_cnt_reg - 5'h01;
        case (state_reg)
          ST_IDLE:
          begin
            // start opcode while running is ignored by the state guard
            if (op_start || pin_rise_ok)
            begin
              state_reg      <= ST_SETTLE; // [R5] [R27]
              settle_cnt_reg <= settling_delay;
              data_ready_n   <= 1'b1; // [R9]
              filter_reset   <= 1'b1; // [R18]
              converting     <= 1'b1;
              stop_pend_reg  <= 1'b0;
            end
          end
          ST_SETTLE, ST_RUN:
          begin
            if (settle_cnt_reg == 17'h1)
            begin
              data_ready_n   <= 1'b0; // [R9] [R6]
              load_reg       <= 1'b1;
              state_reg      <= ST_RUN; // [R12]
              settle_cnt_reg <= period;
              // a stop within the last 16 clocks lets one more frame run
              if (single_mode || (stop_pend_reg && halt_cnt_reg == 5'h0))
              begin
                state_reg  <= ST_IDLE; // [R16] [R14]
                converting <= 1'b0;
              end
            end
            else
              settle_cnt_reg <= settle_cnt_reg - 17'h1;
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end

  serial_frame_shift u_shift
  (
    .clk       (clk),
    .rst_n     (rst_n),
    .sclk_rise (sclk_rise),
    .cs_n      (cs_s_reg[1]),
    .chain_in  (ci_s_reg[1]),
    .chain_en  (chain_en),
    .load      (load_reg),
    .frame     ({`STATUS_PATTERN, lead_off_bits, gpio_levels,
                 channel_data}), // [R25]
    .sdo_out   (sdo_out),
    .sdo_oe    (sdo_oe)
  );
endmodule // conv_sync_ctrl

// ==== pkg/conv_sync_defines.vh ====
`ifndef CONV_SYNC_DEFINES_VH
`define CONV_SYNC_DEFINES_VH
// serial opcodes
`define OP_START        8'h08
`define OP_STOP         8'h0a
`define OP_RESET        8'h06
`define OP_REGISTER_WRITE_CMD_HI      3'h2
// register addresses used by the write decode
`define ADDR_RATE_CHAIN 5'h01
`define ADDR_RESPIRATION_CTRL_REG       5'h09
`define ADDR_MISC_MODE  5'h17
// field positions
`define MISC_SINGLE_BIT 3
`define RATE_CHAIN_BIT  6
`define RATE_SEL_MSB    2
// reset values
`define RATE_CHAIN_RST  8'h06
`define MISC_MODE_RST   8'h00
`define RESPIRATION_CTRL_REG_RST        8'h00
// timing in conversion-clock periods
`define RESET_CYCLES    5'h12
`define START_MIN_HIGH  2'h2
`define HALT_FINISH     5'h10
`define SETTLE_000      17'h00488
`define SETTLE_001      17'h00908
`define SETTLE_010      17'h01208
`define SETTLE_011      17'h02408
`define SETTLE_100      17'h04808
`define SETTLE_101      17'h09008
`define SETTLE_110      17'h12008
// frame layout
`define STATUS_BITS     8'h18
`define STATUS_PATTERN  4'hc
`define FRAME_BITS      8'h98
`endif

// ==== rtl/serial_frame_shift.v ====
`timescale 1ns/1ns
`include "conv_sync_defines.vh"
// shifts one output frame; in chain mode appends bits taken from chain input
module serial_frame_shift
(
  // clock and reset
  input  wire         clk,
  input  wire         rst_n,
  // sampled serial pins
  input  wire         sclk_rise,
  input  wire         cs_n,
  input  wire         chain_in,
  // control
  input  wire         chain_en,
  input  wire         load,
  input  wire [151:0] frame,
  // output pin
  output reg          sdo_out,
  output wire         sdo_oe
);
  reg [151:0] shift_reg;
  reg [7:0]   count_reg;

  // a deselected device releases the shared line
  assign sdo_oe = ~cs_n; // [R19]

  // each rising edge drives the next bit; in chain mode it also takes in the chain bit
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shift_reg <= 152'h0;
      count_reg <= 8'h00;
      sdo_out   <= 1'b0;
    end
    else if (load)
    begin
      shift_reg <= frame;
      count_reg <= 8'h00;
    end
    else if (sclk_rise && !cs_n)
    begin
      sdo_out   <= shift_reg[151];
      count_reg <= count_reg + 8'h01;
      if (chain_en)
        shift_reg <= {shift_reg[150:0], chain_in}; // [R23] [R20] [R21]
      else if (count_reg == `FRAME_BITS - 8'h01)
        shift_reg <= frame; // repeat readback, standard mode only [R22]
      else
        shift_reg <= {shift_reg[150:0], shift_reg[151]};
    end
  end
endmodule // serial_frame_shift

// ==== tb/conv_sync_ctrl_assertions.sv ====
`timescale 1ns/1ns
// pin-level timing checks for the conversion controller
module conv_sync_ctrl_assertions
(
  // clock and reset
  input wire       clk,
  input wire       rstn,
  // pins
  input wire       reset_pin_n,
  input wire       start_pin,
  input wire       cs_n,
  input wire       sdo_oe,
  input wire       data_ready_n,
  // status
  input wire       filter_reset,
  input wire       converting,
  input wire       init_busy,
  input wire [2:0] rate_select,
  input wire       chain_en,
  input wire       single_mode
);
  reg [5:0] init_cnt_reg;
  reg       arm_reg;
  reg [1:0] rpin_d_reg;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // init length; the first init after rstn is skipped, its start is fuzzy;
  // a held reset pin restarts the count, seen with the design's 2-flop lag
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      init_cnt_reg <= 6'h00;
      arm_reg <= 1'b0;
      rpin_d_reg <= 2'h3;
    end
    else
    begin
      arm_reg <= arm_reg | !init_busy;
      rpin_d_reg <= {rpin_d_reg[0], reset_pin_n};
      if (!init_busy || !rpin_d_reg[1])
        init_cnt_reg <= 6'h00;
      else if (init_cnt_reg != 6'h3f)
        init_cnt_reg <= init_cnt_reg + 6'h01;
    end
  end
  property p_oe_cs;
    ((cs_n)[*4] |-> !sdo_oe) and ((!cs_n)[*4] |-> sdo_oe);
  endproperty
  property p_init_len;
    $fell(init_busy) && arm_reg |-> init_cnt_reg == 6'h12;
  endproperty
  property p_init_idle;
    init_busy && $past(init_busy) |-> !converting && data_ready_n;
  endproperty
  property p_defaults;
    $fell(init_busy) |-> rate_select == 3'h6 && !chain_en && !single_mode;
  endproperty
  property p_fall_conv;
    $fell(data_ready_n) |-> $past(converting);
  endproperty
  property p_idle_quiet;
    !converting && data_ready_n |=> data_ready_n;
  endproperty
  property p_start_high;
    $rose(converting) |-> data_ready_n;
  endproperty
  property p_start_filter;
    $rose(converting) |-> filter_reset || $past(filter_reset);
  endproperty
  property p_single_hold;
    (cs_n && !start_pin && reset_pin_n)[*4] ##0
      (!data_ready_n && !converting) |=> !data_ready_n;
  endproperty
  a_oe_cs: assert property (p_oe_cs)
    else $error("output enable not following select");
  a_init_len: assert property (p_init_len)
    else $error("init length wrong");
  a_init_idle: assert property (p_init_idle)
    else $error("activity during init");
  a_defaults: assert property (p_defaults)
    else $error("defaults not restored");
  a_fall_conv: assert property (p_fall_conv)
    else $error("ready fell while halted");
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("ready pulse while halted");
  a_start_high: assert property (p_start_high)
    else $error("ready low at start");
  a_start_filter: assert property (p_start_filter)
    else $error("no filter reset at start");
  a_single_hold: assert property (p_single_hold)
    else $error("ready released with no cause");
  c_single: cover property (single_mode && $fell(data_ready_n));
  c_init: cover property ($fell(init_busy) && arm_reg);
  c_start: cover property ($rose(converting));
endmodule // conv_sync_ctrl_assertions

bind conv_sync_ctrl conv_sync_ctrl_assertions chk_i
(
  .clk, .rstn, .reset_pin_n, .start_pin, .cs_n, .sdo_oe, .data_ready_n,
  .filter_reset, .converting, .init_busy, .rate_select, .chain_en,
  .single_mode
);

// ==== tb/host_serial_model.sv ====
`timescale 1ns/1ns
// host side of the serial port; clock idles low between bytes
module host_serial_model
(
  // serial pins
  output reg  sclk,
  output reg  cs_n,
  output reg  sdi,
  input  wire sdo
);
  localparam HALF = 80;
  // idle: deselected, clock still
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b1;
  end
  // one whole byte msb first; select stays low for the command
  task xfer(input [7:0] b, output [7:0] r);
    integer i;
    begin
      #3 cs_n = 1'b0;
      // data moves on the rise so it is steady across the sampling fall
      for (i = 7; i >= 0; i = i - 1)
      begin
        #HALF sclk = 1'b1;
        sdi = b[i];
        #HALF r[i] = sdo;
        sclk = 1'b0;
      end
    end
  endtask
  // ends the command after the last hold time
  task release_bus;
    begin
      #HALF cs_n = 1'b1;
      // flipped so a stale bit never looks held
      sdi = ~sdi;
    end
  endtask
endmodule // host_serial_model

// ==== tb/conv_sync_ctrl_test.sv ====
`timescale 1ns/1ns
// self-checking bench for the conversion controller
module conv_sync_ctrl_test;
  reg         clk, rstn, reset_pin_n, start_pin, clk_oe;
  wire        sclk, cs_n, sdi, sdo_out, sdo_oe, data_ready_n;
  wire        sdo_bus, ck_out;
  wire        filter_reset, converting, init_busy, chain_en, single_mode;
  wire [2:0]  rate_select;
  integer     bad_count, cmp_count, cyc, fr_cnt, n;
  time        t0;
  reg [7:0]   r;
  conv_sync_ctrl uut
  (
    .clk(clk), .rstn(rstn), .reset_pin_n(reset_pin_n),
    .start_pin(start_pin), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
    .chain_in(~sdi), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
    .data_ready_n(data_ready_n), .clock_source_select(1'b1),
    .clk_out_en(clk_oe), .clk_out(ck_out), .lead_off_bits(16'ha5c3),
    .gpio_levels(4'h9), .channel_data({8{16'h1234}}),
    .filter_reset(filter_reset), .converting(converting),
    .init_busy(init_busy), .rate_select(rate_select),
    .chain_en(chain_en), .single_mode(single_mode)
  );
  // a released line shows the inverse, so a read while deselected fails
  assign sdo_bus = sdo_oe ? sdo_out : ~sdo_out;
  host_serial_model hm (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo_bus));
  // clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // cycle ceiling and filter reset count
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (filter_reset === 1'b1)
      fr_cnt = fr_cnt + 1;
    if (cyc == 20000)
    begin
      bad_count = bad_count + 1;
      end_sim;
    end
  end
  always @(posedge converting)
    t0 = $time;
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp)
      begin
        bad_count = bad_count + 1;
        $display("BAD %0t seen %0h exp %0h", $time, seen, exp);
      end
    end
  endtask
  function pick(input [1:0] w);
    pick = w == 0 ? data_ready_n : w == 1 ? converting : init_busy;
  endfunction
  // bounded wait for a level: 0 ready, 1 converting, 2 init
  task wait_for(input [1:0] w, input v, input integer lim);
    begin
      n = 0;
      while (pick(w) !== v && n < lim)
      begin
        @(posedge clk);
        #1 n = n + 1;
      end
      chk(pick(w), v);
    end
  endtask
  // bytes then release; a few clocks let the decode land
  task send(input [23:0] b, input integer cnt);
    integer i;
    begin
      for (i = cnt - 1; i >= 0; i = i - 1)
        hm.xfer(b[8*i +: 8], r);
      chk(sdo_oe, 1'b1);
      hm.release_bus;
      repeat (4) @(posedge clk);
      #1;
    end
  endtask
  task end_sim;
    begin
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  initial
  begin
    rstn = 1'b0;
    reset_pin_n = 1'b1;
    start_pin = 1'b0;
    clk_oe = 1'b0;
    {bad_count, cmp_count, cyc, fr_cnt} = 128'h0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    wait_for(2, 1'b0, 40);
    chk({rate_select, chain_en, single_mode, data_ready_n}, 6'h31);
    chk(sdo_oe, 1'b0);
    chk(ck_out, 1'b0);
    @(posedge clk) clk_oe <= 1'b1;
    #1 chk(ck_out, 1'b1);
    send(24'h570000, 3);
    chk(fr_cnt, 0);
    send(24'h490002, 3);
    chk(fr_cnt, 1);
    send(24'h410000, 3);
    chk({fr_cnt[7:0], rate_select}, 11'h010);
    repeat (300) @(posedge clk);
    #1 chk({converting, data_ready_n}, 2'h1);
    send(24'h000008, 1);
    chk({converting, data_ready_n, fr_cnt[3:0]}, 6'h33);
    wait_for(0, 1'b0, 1300);
    n = ($time - t0) / 10;
    chk(n >= 1150 && n <= 1165, 1'b1);
    send(24'h000000, 1);
    chk(r, 8'hca);
    wait_for(0, 1'b0, 400);
    send(24'h000000, 1);
    send(24'h00000a, 1);
    chk(converting, 1'b1);
    wait_for(1, 1'b0, 400);
    chk(data_ready_n, 1'b0);
    send(24'h000000, 1);
    repeat (700) @(posedge clk);
    #1 chk({converting, data_ready_n}, 2'h1);
    @(posedge clk) start_pin <= 1'b1;
    @(posedge clk) start_pin <= 1'b0;
    repeat (10) @(posedge clk);
    #1 chk(converting, 1'b0);
    @(posedge clk) start_pin <= 1'b1;
    wait_for(1, 1'b1, 10);
    @(posedge clk) start_pin <= 1'b0;
    wait_for(1, 1'b0, 1300);
    chk(fr_cnt, 4);
    send(24'h570008, 3);
    chk(single_mode, 1'b1);
    @(posedge clk) start_pin <= 1'b1;
    wait_for(0, 1'b1, 10);
    wait_for(0, 1'b0, 1300);
    @(posedge clk) start_pin <= 1'b0;
    repeat (700) @(posedge clk);
    #1 chk({converting, data_ready_n}, 2'h0);
    send(24'h000008, 1);
    chk({converting, fr_cnt[3:0]}, 5'h16);
    wait_for(0, 1'b0, 1300);
    send(24'h410040, 3);
    chk(chain_en, 1'b1);
    send(24'h000006, 1);
    chk(init_busy, 1'b1);
    wait_for(2, 1'b0, 30);
    chk({rate_select, chain_en, single_mode}, 5'h18);
    send(24'h570008, 3);
    @(posedge clk) reset_pin_n <= 1'b0;
    wait_for(2, 1'b1, 10);
    @(posedge clk) reset_pin_n <= 1'b1;
    wait_for(2, 1'b0, 40);
    chk(single_mode, 1'b0);
    end_sim;
  end
endmodule // conv_sync_ctrl_test
